// ==== logic/rcs_map.svh ====
// Addresses, register offsets, reset values and sizes of the context block
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

// On-chip RAM window, 1 KByte ending at the top of the bit area
`define RCS_RAM_BASE       16'hfa00
`define RCS_RAM_BYTES      1024
`define RCS_RAM_WORDS      512
`define RCS_RAM_AW         9
`define RCS_STACK_MAX      1024

// Special areas inside the RAM
`define RCS_PEC_LO         16'hfce0
`define RCS_PEC_HI         16'hfcff
`define RCS_BIT_LO         16'hfd00
`define RCS_BIT_HI         16'hfdff

// Register context
`define RCS_GPR_COUNT      16
`define RCS_STEP           16'h0002

// APB register byte offsets
`define RCS_OFF_CBP        12'h000
`define RCS_OFF_SP         12'h004
`define RCS_OFF_OVL        12'h008
`define RCS_OFF_UNL        12'h00c
`define RCS_OFF_STAT       12'h010

// Status bit positions
`define RCS_STAT_OVF       0
`define RCS_STAT_UNF       1

// Reset values
`define RCS_RST_CBP        16'hfc00
`define RCS_RST_SP         16'hfc00
`define RCS_RST_OVL        16'hfa00
`define RCS_RST_UNL        16'hfc00

`endif

// ==== logic/rcs_pkg.sv ====
// Types shared by the register context and stack check logic
package rcs_pkg;

    // Operation requested by the execution core
    typedef enum logic [2:0] {
        RCS_OP_NONE   = 3'b000,
        RCS_OP_GPR_RD = 3'b001,
        RCS_OP_GPR_WR = 3'b010,
        RCS_OP_PUSH   = 3'b011,
        RCS_OP_POP    = 3'b100,
        RCS_OP_MEM_RD = 3'b101,
        RCS_OP_MEM_WR = 3'b110
    } rcs_op_e;

    // One request per cycle from the core
    typedef struct packed {
        rcs_op_e     op;
        logic [3:0]  reg_idx;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rcs_req_s;

    // Read answer, one cycle after the request
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic        pec_area;
        logic        bit_area;
    } rcs_rsp_s;

    // Stack limit event towards the trap logic
    typedef struct packed {
        logic pulse;
        logic overflow;
        logic underflow;
    } rcs_trap_s;

endpackage : rcs_pkg

// ==== logic/rcs_ram.sv ====
// Single-port 512 x 16 on-chip RAM with synchronous read
`timescale 1ns/1ns
`include "rcs_map.svh"

module rcs_ram (
    input  wire logic                     clk_in,    // System clock
    input  wire logic                     we_in,     // Write strobe
    input  wire logic [`RCS_RAM_AW-1:0]   addr_in,   // Word index
    input  wire logic [15:0]              wdata_in,  // Write data
    output logic      [15:0]              rdata_out  // Read data, registered
);

    logic [15:0] mem [0:`RCS_RAM_WORDS-1];

    // Read-before-write; contents are undefined after power-up as in silicon
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end

endmodule : rcs_ram

// ==== logic/rcs_context_stack.sv ====
// Register context, system stack and stack limit checking over on-chip RAM
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "rcs_map.svh"

module rcs_context_stack (
    input  wire logic                clk_in,      // 100 MHz system clock
    input  wire logic                reset_n_in,  // Synchronous reset, low
    input  wire logic                psel,        // APB select
    input  wire logic                penable,     // APB access phase
    input  wire logic                pwrite,      // APB write
    input  wire logic [11:0]         paddr,       // APB byte address
    input  wire logic [31:0]         pwdata,      // APB write data
    output logic      [31:0]         prdata,      // APB read data
    output logic                     pready,      // APB ready
    output logic                     pslverr,     // APB unmapped offset
    input  wire rcs_pkg::rcs_req_s   req_in,      // Core request
    output rcs_pkg::rcs_rsp_s        rsp_out,     // Read answer
    output rcs_pkg::rcs_trap_s       trap_out,    // Stack limit event
    output logic      [15:0]         cbp_out,     // Context base pointer
    output logic      [15:0]         sp_out       // Stack top pointer
);

    logic [15:0] context_base_pointer_r;
    logic [15:0] stack_top_pointer_r;
    logic [15:0] stack_overflow_limit_r;
    logic [15:0] stack_underflow_limit_r;
    logic        ovf_flag_r;
    logic        unf_flag_r;
    logic        rd_pend_r;
    logic        pec_area_r;
    logic        bit_area_r;
    logic        trap_r;
    logic        trap_ovf_r;
    logic        trap_unf_r;
    logic [15:0] acc_addr;
    logic [15:0] sp_dec;
    logic [15:0] sp_inc;
    logic [15:0] ram_off;
    logic [15:0] ram_rdata;
    logic        ram_we;
    logic        is_push;
    logic        is_pop;
    logic        is_read;
    logic        ovf_hit;
    logic        unf_hit;
    logic        apb_wr;
    logic        mapped;
    logic        stat_clr_ovf;
    logic        stat_clr_unf;

    rcs_pkg::rcs_op_e op;

    assign op      = req_in.op;
    assign is_push = (op == rcs_pkg::RCS_OP_PUSH);
    assign is_pop  = (op == rcs_pkg::RCS_OP_POP);
    assign is_read = (op == rcs_pkg::RCS_OP_GPR_RD) ||
                     (op == rcs_pkg::RCS_OP_POP) ||
                     (op == rcs_pkg::RCS_OP_MEM_RD);
    assign sp_dec  = stack_top_pointer_r - `RCS_STEP;
    assign sp_inc  = stack_top_pointer_r + `RCS_STEP;

    // Pre-decrement push, post-increment pop
    assign ovf_hit = is_push && (sp_dec < stack_overflow_limit_r);
    assign unf_hit = is_pop && (sp_inc > stack_underflow_limit_r);

    // Access address; banks are not checked against each other on purpose
    always_comb begin
        acc_addr = 16'h0000;
        ram_we   = 1'b0;
        unique case (op)
            rcs_pkg::RCS_OP_GPR_RD: begin
                acc_addr = context_base_pointer_r +
                           {11'h000, req_in.reg_idx, 1'b0};
            end
            rcs_pkg::RCS_OP_GPR_WR: begin
                acc_addr = context_base_pointer_r +
                           {11'h000, req_in.reg_idx, 1'b0};
                ram_we   = 1'b1;
            end
            rcs_pkg::RCS_OP_PUSH: begin
                acc_addr = sp_dec;
                ram_we   = 1'b1;
            end
            rcs_pkg::RCS_OP_POP: begin
                acc_addr = stack_top_pointer_r;
            end
            rcs_pkg::RCS_OP_MEM_RD: begin
                acc_addr = req_in.addr;
            end
            rcs_pkg::RCS_OP_MEM_WR: begin
                acc_addr = req_in.addr;
                ram_we   = 1'b1;
            end
            default: begin
                acc_addr = 16'h0000;
            end
        endcase
    end

    // Offset into the RAM window; addresses outside it wrap into it
    assign ram_off = acc_addr - `RCS_RAM_BASE;

    // General registers, stack and variables all share one array
    rcs_ram u_ram (
        .clk_in    (clk_in),
        .we_in     (ram_we),
        .addr_in   (ram_off[`RCS_RAM_AW:1]),
        .wdata_in  (req_in.wdata),
        .rdata_out (ram_rdata)
    );

    // Read answer tracking and area decode, aligned with the RAM output
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rd_pend_r  <= 1'b0;
            pec_area_r <= 1'b0;
            bit_area_r <= 1'b0;
        end else begin
            rd_pend_r  <= is_read;
            pec_area_r <= (acc_addr >= `RCS_PEC_LO) &&
                          (acc_addr <= `RCS_PEC_HI);
            bit_area_r <= (acc_addr >= `RCS_BIT_LO) &&
                          (acc_addr <= `RCS_BIT_HI);
        end
    end

    assign rsp_out.valid    = rd_pend_r;
    assign rsp_out.data     = ram_rdata;
    assign rsp_out.pec_area = pec_area_r;
    assign rsp_out.bit_area = bit_area_r;

    // APB: zero wait states, writes take effect in the access phase
    assign apb_wr  = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign mapped  = (paddr == `RCS_OFF_CBP) || (paddr == `RCS_OFF_SP) ||
                     (paddr == `RCS_OFF_OVL) || (paddr == `RCS_OFF_UNL) ||
                     (paddr == `RCS_OFF_STAT);
    assign pslverr = psel && penable && !mapped;

    // Pointer and limit registers; a core stack op beats a bus write to SP
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            context_base_pointer_r  <= `RCS_RST_CBP;
            stack_top_pointer_r     <= `RCS_RST_SP;
            stack_overflow_limit_r  <= `RCS_RST_OVL;
            stack_underflow_limit_r <= `RCS_RST_UNL;
        end else begin
            if (apb_wr && paddr == `RCS_OFF_CBP) begin
                context_base_pointer_r <= pwdata[15:0];
            end
            if (apb_wr && paddr == `RCS_OFF_OVL) begin
                stack_overflow_limit_r <= pwdata[15:0];
            end
            if (apb_wr && paddr == `RCS_OFF_UNL) begin
                stack_underflow_limit_r <= pwdata[15:0];
            end
            if (is_push) begin
                stack_top_pointer_r <= sp_dec;
            end else if (is_pop) begin
                stack_top_pointer_r <= sp_inc;
            end else if (apb_wr && paddr == `RCS_OFF_SP) begin
                stack_top_pointer_r <= pwdata[15:0];
            end
        end
    end

    // Sticky cause flags, write one to clear; a new hit wins over the clear
    assign stat_clr_ovf = apb_wr && (paddr == `RCS_OFF_STAT) &&
                          pwdata[`RCS_STAT_OVF];
    assign stat_clr_unf = apb_wr && (paddr == `RCS_OFF_STAT) &&
                          pwdata[`RCS_STAT_UNF];

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ovf_flag_r <= 1'b0;
            unf_flag_r <= 1'b0;
        end else begin
            ovf_flag_r <= ovf_hit || (ovf_flag_r && !stat_clr_ovf);
            unf_flag_r <= unf_hit || (unf_flag_r && !stat_clr_unf);
        end
    end

    // Trap event: one cycle per violating access, cause alongside
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            trap_r     <= 1'b0;
            trap_ovf_r <= 1'b0;
            trap_unf_r <= 1'b0;
        end else begin
            trap_r     <= ovf_hit || unf_hit;
            trap_ovf_r <= ovf_hit;
            trap_unf_r <= unf_hit;
        end
    end

    assign trap_out.pulse     = trap_r;
    assign trap_out.overflow  = trap_ovf_r;
    assign trap_out.underflow = trap_unf_r;
    assign cbp_out            = context_base_pointer_r;
    assign sp_out             = stack_top_pointer_r;

    // Read word taken at the setup edge so bus data comes from a flop;
    // a pointer change during the access phase shows on the next read
    always_ff @(posedge clk_in) begin
        if (psel && !penable) begin
            unique case (paddr)
                `RCS_OFF_CBP:  prdata <= {16'h0000, context_base_pointer_r};
                `RCS_OFF_SP:   prdata <= {16'h0000, stack_top_pointer_r};
                `RCS_OFF_OVL:  prdata <= {16'h0000, stack_overflow_limit_r};
                `RCS_OFF_UNL:  prdata <= {16'h0000, stack_underflow_limit_r};
                `RCS_OFF_STAT: prdata <= {30'h0, unf_flag_r, ovf_flag_r};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks on the behaviour above
    sequence s_push;
        req_in.op == rcs_pkg::RCS_OP_PUSH;
    endsequence

    sequence s_pop;
        req_in.op == rcs_pkg::RCS_OP_POP;
    endsequence

    a_gpr_addr_form: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (op == rcs_pkg::RCS_OP_GPR_RD || op == rcs_pkg::RCS_OP_GPR_WR) |->
        acc_addr == context_base_pointer_r + 16'(2 * req_in.reg_idx))
        else $error("general register address not base plus twice index");

    a_push_sp_step: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s_push |=> stack_top_pointer_r == $past(stack_top_pointer_r) - 16'h0002)
        else $error("push did not lower the stack pointer by two");

    a_pop_sp_step: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s_pop |=> stack_top_pointer_r == $past(stack_top_pointer_r) + 16'h0002)
        else $error("pop did not raise the stack pointer by two");

    a_ovf_trap_seen: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (s_push ##0 (16'(stack_top_pointer_r - 16'h0002) <
                     stack_overflow_limit_r)) |=>
        (trap_out.pulse && trap_out.overflow && ovf_flag_r))
        else $error("overflow push gave no overflow trap");

    a_unf_trap_seen: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (s_pop ##0 (16'(stack_top_pointer_r + 16'h0002) >
                    stack_underflow_limit_r)) |=>
        (trap_out.pulse && trap_out.underflow && unf_flag_r))
        else $error("underflow pop gave no underflow trap");

    a_trap_has_cause: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        trap_out.pulse |-> $past(is_push || is_pop) &&
        (trap_out.overflow != trap_out.underflow))
        else $error("trap without a stack access or a single cause");

    a_flag_sticky: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (ovf_flag_r && !stat_clr_ovf) |=> ovf_flag_r)
        else $error("overflow flag dropped without a clear");

    a_read_answer: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        is_read |=> rsp_out.valid)
        else $error("read request not answered next cycle");

    a_bit_area_dec: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        rsp_out.bit_area |-> ($past(acc_addr) >= `RCS_BIT_LO &&
                              $past(acc_addr) <= `RCS_BIT_HI))
        else $error("bit area flagged outside its range");

    a_pec_area_dec: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        rsp_out.pec_area |-> ($past(acc_addr) >= `RCS_PEC_LO &&
                              $past(acc_addr) <= `RCS_PEC_HI))
        else $error("pointer area flagged outside its range");

endmodule : rcs_context_stack

// ==== verif/rcs_core_model.sv ====
// Behavioural model of the execution core that feeds the request port
`timescale 1ns/1ns

module rcs_core_model (
    input  wire logic         clk_in,  // System clock
    output rcs_pkg::rcs_req_s req_out  // Request to the block
);
    // Idle at time zero so nothing is taken during reset
    initial req_out = '0;

    // One request, launched after an edge and taken at the next one
    task automatic issue(input rcs_pkg::rcs_op_e o, input logic [3:0] i,
                         input logic [15:0] a, input logic [15:0] w);
        @(posedge clk_in);
        req_out <= '{o, i, a, w};
        @(posedge clk_in);
        req_out.op    <= rcs_pkg::RCS_OP_NONE;
        // Idle data flips so a stale word never looks like a live one
        req_out.wdata <= ~w;
    endtask : issue
endmodule : rcs_core_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the register context and stack check block
`timescale 1ns/1ns
`include "rcs_map.svh"

module tb_top;
    logic               clk_in     = 1'b0;
    logic               reset_n_in = 1'b0;
    logic               psel       = 1'b0;
    logic               penable    = 1'b0;
    logic               pwrite     = 1'b0;
    logic [11:0]        paddr      = 12'h000;
    logic [31:0]        pwdata     = 32'h0000_0000;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    rcs_pkg::rcs_req_s  req;
    rcs_pkg::rcs_rsp_s  rsp;
    rcs_pkg::rcs_trap_s trap;
    logic [15:0]        cbp;
    logic [15:0]        sp;
    logic [31:0]        rd;
    logic               err;
    int                 error_cnt  = 0;
    int                 n_compared = 0;

    // 100 MHz clock
    always #5 clk_in = ~clk_in;

    rcs_core_model rcs_core_model_i (.clk_in(clk_in), .req_out(req));

    rcs_context_stack rcs_context_stack_i (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_in(req), .rsp_out(rsp),
        .trap_out(trap), .cbp_out(cbp), .sp_out(sp)
    );

    // Single comparison point, unknowns never match
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // APB transfer; waits for pready, takes data at that same edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic rchk(input string nm, input logic [11:0] a,
                        input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
        chk({nm, " slverr"}, {31'h0, ee}, {31'h0, err});
    endtask : rchk

    task automatic op(input rcs_pkg::rcs_op_e o, input logic [3:0] i,
                      input logic [15:0] a, input logic [15:0] w);
        rcs_core_model_i.issue(o, i, a, w);
        #1;
    endtask : op

    task automatic rsp_chk(input string nm, input logic [15:0] d);
        chk({nm, " valid"}, 32'h1, {31'h0, rsp.valid});
        chk(nm, {16'h0, d}, {16'h0, rsp.data});
    endtask : rsp_chk

    task automatic t_reset;
        rchk("cbp", `RCS_OFF_CBP, 32'h0000_fc00, 1'b0);
        rchk("sp", `RCS_OFF_SP, 32'h0000_fc00, 1'b0);
        rchk("ovl", `RCS_OFF_OVL, 32'h0000_fa00, 1'b0);
        rchk("unl", `RCS_OFF_UNL, 32'h0000_fc00, 1'b0);
        rchk("stat", `RCS_OFF_STAT, 32'h0, 1'b0);
        rchk("unmapped", 12'h014, 32'h0, 1'b1);
    endtask : t_reset

    task automatic t_gpr;
        apb(1'b1, `RCS_OFF_CBP, 32'hffff_fb00);
        chk("cbp_out", 32'h0000_fb00, {16'h0, cbp});
        for (int n = 0; n < 16; n++) begin
            op(rcs_pkg::RCS_OP_GPR_WR, 4'(n), 16'h0, 16'ha500 + 16'(n));
        end
        // Each register must land at base plus twice its index
        for (int n = 0; n < 16; n++) begin
            op(rcs_pkg::RCS_OP_MEM_RD, 4'h0, 16'hfb00 + 16'(2 * n), 16'h0);
            rsp_chk("gpr by addr", 16'ha500 + 16'(n));
        end
        apb(1'b1, `RCS_OFF_CBP, 32'h0000_fb02);
        op(rcs_pkg::RCS_OP_GPR_RD, 4'h2, 16'h0, 16'h0);
        rsp_chk("overlap gpr", 16'ha503);
        op(rcs_pkg::RCS_OP_GPR_WR, 4'h0, 16'h0, 16'h5a5a);
        op(rcs_pkg::RCS_OP_MEM_RD, 4'h0, 16'hfb02, 16'h0);
        rsp_chk("new bank base", 16'h5a5a);
    endtask : t_gpr

    task automatic t_stack;
        apb(1'b1, `RCS_OFF_SP, 32'h0000_fc00);
        op(rcs_pkg::RCS_OP_PUSH, 4'h0, 16'h0, 16'h1111);
        op(rcs_pkg::RCS_OP_PUSH, 4'h0, 16'h0, 16'h2222);
        chk("sp pushed", 32'h0000_fbfc, {16'h0, sp});
        op(rcs_pkg::RCS_OP_MEM_RD, 4'h0, 16'hfbfc, 16'h0);
        rsp_chk("stack top", 16'h2222);
        op(rcs_pkg::RCS_OP_POP, 4'h0, 16'h0, 16'h0);
        rsp_chk("pop 1", 16'h2222);
        op(rcs_pkg::RCS_OP_POP, 4'h0, 16'h0, 16'h0);
        rsp_chk("pop 2", 16'h1111);
        chk("no trap", 32'h0, {31'h0, trap.pulse});
        chk("sp popped", 32'h0000_fc00, {16'h0, sp});
    endtask : t_stack

    task automatic t_limits;
        apb(1'b1, `RCS_OFF_OVL, 32'h0000_fbfe);
        op(rcs_pkg::RCS_OP_PUSH, 4'h0, 16'h0, 16'h3333);
        chk("at limit", 32'h0, {31'h0, trap.pulse});
        op(rcs_pkg::RCS_OP_PUSH, 4'h0, 16'h0, 16'h4444);
        chk("ovf trap", 32'h6, {29'h0, trap});
        @(posedge clk_in);
        #1;
        chk("trap width", 32'h0, {31'h0, trap.pulse});
        rchk("stat ovf", `RCS_OFF_STAT, 32'h1, 1'b0);
        apb(1'b1, `RCS_OFF_STAT, 32'h1);
        rchk("stat clr", `RCS_OFF_STAT, 32'h0, 1'b0);
        op(rcs_pkg::RCS_OP_POP, 4'h0, 16'h0, 16'h0);
        op(rcs_pkg::RCS_OP_POP, 4'h0, 16'h0, 16'h0);
        chk("unl edge", 32'h0, {31'h0, trap.pulse});
        op(rcs_pkg::RCS_OP_POP, 4'h0, 16'h0, 16'h0);
        chk("unf trap", 32'h5, {29'h0, trap});
        rchk("stat unf", `RCS_OFF_STAT, 32'h2, 1'b0);
        apb(1'b1, `RCS_OFF_STAT, 32'h2);
        // A raised underflow limit must move the point at which a pop traps
        apb(1'b1, `RCS_OFF_UNL, 32'h0000_fc04);
        rchk("unl wr", `RCS_OFF_UNL, 32'h0000_fc04, 1'b0);
        op(rcs_pkg::RCS_OP_POP, 4'h0, 16'h0, 16'h0);
        chk("unl moved", 32'h0, {31'h0, trap.pulse});
        op(rcs_pkg::RCS_OP_POP, 4'h0, 16'h0, 16'h0);
        chk("unl moved trap", 32'h5, {29'h0, trap});
    endtask : t_limits

    task automatic t_areas;
        logic [15:0] a [5] = '{16'hfcde, 16'hfce0, 16'hfcfe, 16'hfd00,
                               16'hfdfe};
        logic [1:0]  f [5] = '{2'b00, 2'b10, 2'b10, 2'b01, 2'b01};
        // Both edges of each special area, plus the word below them
        for (int i = 0; i < 5; i++) begin
            op(rcs_pkg::RCS_OP_MEM_WR, 4'h0, a[i], 16'hc000 + 16'(i));
            op(rcs_pkg::RCS_OP_MEM_RD, 4'h0, a[i], 16'h0);
            rsp_chk("area data", 16'hc000 + 16'(i));
            chk("area flags", {30'h0, f[i]},
                {30'h0, rsp.pec_area, rsp.bit_area});
        end
        op(rcs_pkg::RCS_OP_MEM_WR, 4'h0, 16'hfa00, 16'h7e7e);
        op(rcs_pkg::RCS_OP_MEM_RD, 4'h0, 16'hfe00, 16'h0);
        rsp_chk("wrap high", 16'h7e7e);
        op(rcs_pkg::RCS_OP_MEM_RD, 4'h0, 16'hf9fe, 16'h0);
        rsp_chk("wrap low", 16'hc004);
    endtask : t_areas

    // Reset again mid-run: every register and flag must be back at default
    task automatic t_rerun;
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_reset;
    endtask : t_rerun

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // Main sequence after a two-cycle reset
    initial begin
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_reset;
        t_gpr;
        t_stack;
        t_limits;
        t_areas;
        t_rerun;
        close_out;
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #50000;
        error_cnt++;
        close_out;
    end
endmodule : tb_top
